/* File: eeprom_host_ctl.sv */
// Function
// - Manual sequence: latch, data, enable, wait, clear
// - Auto mode polls enable bit until cleared
// - Poll timeout still clears enable then latch
// - Chained writes keep latch between operations
// - Keep high shadow bits 7..2 at one
// - Load dividers before any program or erase
// - Initialise dividers right after reset
// - Special mode: dividers, unprotect, unhide shadow
// - Program only divider bits of shadow
// - Reprotect shadow after programming it
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "eeprom_ctl_defines.svh"

module eeprom_host_ctl #(
  parameter int PROGRAM_CYCLES_US = `PROGRAM_TIME_US,
  parameter int POLL_TIMEOUT_US = `POLL_TIMEOUT_US,
  parameter logic [9:0] DIV_RESET = `DIV_DEFAULT,
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  input wire logic special_mode_n,
  output logic [ADDR_W-1:0] dev_addr,
  output logic [DATA_W-1:0] dev_wdata,
  output logic dev_we,
  output logic dev_re,
  input wire logic [DATA_W-1:0] dev_rdata
);
  typedef enum logic [4:0] {
    S_INIT_H, S_INIT_L, S_IDLE, S_LATCH, S_DATA, S_PGM, S_WAIT, S_POLL_RD, S_POLL_CHK,
    S_CLR_PGM, S_CLR_LAT, S_SH_DIVH, S_SH_DIVL, S_SH_UNPROT, S_SH_SHOW, S_SH_PROT, S_DONE
  } state_e;

  function automatic eeprom_ctl_pkg::ctl_s make_ctl(input eeprom_ctl_pkg::cmd_s c,
                                                    input logic lat, input logic pgm);
    eeprom_ctl_pkg::ctl_s v;
    v = '0;
    v.bulk_protect = c.bulk_protect;
    v.auto_clear = c.auto_clear;
    v.byte_sel = c.byte_sel;
    v.row_sel = c.row_sel;
    v.erase = (c.op == eeprom_ctl_pkg::OP_ERASE);
    v.address_data_latch_enable = lat;
    v.program_voltage_enable = pgm;
    return v;
  endfunction

  state_e state;
  eeprom_ctl_pkg::cmd_s cmd;
  logic [ADDR_W-1:0] op_addr;
  logic [DATA_W-1:0] op_data;
  logic [9:0] div_value;
  logic [1:0] shadow_phase;
  logic latch_held;
  logic div_loaded;
  logic ev_done;
  logic ev_timeout;
  logic ev_refused;
  logic flag_done;
  logic flag_timeout;
  logic flag_refused;
  logic mode_meta;
  logic mode_sync;
  logic tick;
  logic timer_restart;
  logic timer_expired;
  logic [15:0] timer_limit;
  logic start_req;
  logic status_clear;

  assign start_req = sw_wr && sw_addr == `HREG_CMD && sw_wdata[`CMD_START];
  assign status_clear = sw_wr && sw_addr == `HREG_STATUS;
  assign timer_limit = cmd.auto_clear ? 16'(POLL_TIMEOUT_US) : 16'(PROGRAM_CYCLES_US);

  // Mode strap comes from a pin
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_meta <= 1'b1;
      mode_sync <= 1'b1;
    end else begin
      mode_meta <= special_mode_n;
      mode_sync <= mode_meta;
    end
  end

  tick_divider #(.DIV(`NS_PER_US / `CLK_PERIOD_NS)) u_tick (
    .clk(clk),
    .srst(srst),
    .tick(tick)
  );

  tick_timer #(.W(16)) u_timer (
    .clk(clk),
    .srst(srst),
    .restart(timer_restart),
    .tick(tick),
    .limit(timer_limit),
    .expired(timer_expired)
  );

  // Operand registers
  always_ff @(posedge clk) begin
    if (srst) begin
      op_addr <= '0;
      op_data <= '0;
      div_value <= DIV_RESET;
    end else if (sw_wr && state == S_IDLE) begin
      if (sw_addr == `HREG_ADDR) op_addr <= sw_wdata[ADDR_W-1:0];
      if (sw_addr == `HREG_DATA) op_data <= sw_wdata[DATA_W-1:0];
      if (sw_addr == `HREG_DIV) div_value <= sw_wdata[9:0];
    end else if (state == S_SH_SHOW) begin
      op_addr <= `DEV_SHADOW_HI;
      op_data <= {`SHADOW_HI_KEEP, div_value[9:8]};
    end else if (state == S_CLR_LAT && shadow_phase == 2'h1) begin
      op_addr <= `DEV_SHADOW_LO;
      op_data <= div_value[7:0];
    end
  end

  // Sequencer and device bus
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= S_INIT_H;
      cmd <= '0;
      dev_addr <= '0;
      dev_wdata <= '0;
      dev_we <= 1'b0;
      dev_re <= 1'b0;
      latch_held <= 1'b0;
      div_loaded <= 1'b0;
      shadow_phase <= 2'h0;
      timer_restart <= 1'b0;
      ev_done <= 1'b0;
      ev_timeout <= 1'b0;
      ev_refused <= 1'b0;
    end else begin
      dev_we <= 1'b0;
      dev_re <= 1'b0;
      timer_restart <= 1'b0;
      ev_done <= 1'b0;
      ev_timeout <= 1'b0;
      ev_refused <= 1'b0;
      case (state)
        S_INIT_H: begin
          dev_we <= 1'b1;
          dev_addr <= `DEV_DIVH;
          dev_wdata <= DATA_W'(div_value[9:8]);
          state <= S_INIT_L;
        end
        S_INIT_L: begin
          dev_we <= 1'b1;
          dev_addr <= `DEV_DIVL;
          dev_wdata <= div_value[7:0];
          div_loaded <= 1'b1;
          state <= S_IDLE;
        end
        S_IDLE: begin
          if (start_req) begin
            cmd.op <= eeprom_ctl_pkg::op_e'(sw_wdata[`CMD_OP_HI:`CMD_OP_LO]);
            cmd.auto_clear <= sw_wdata[`CMD_AUTO];
            cmd.byte_sel <= sw_wdata[`CMD_BYTE];
            cmd.row_sel <= sw_wdata[`CMD_ROW];
            cmd.keep_latch <= sw_wdata[`CMD_KEEP_LATCH];
            cmd.bulk_protect <= sw_wdata[`CMD_BULK_PROTECT];
            shadow_phase <= 2'h0;
            if (sw_wdata[`CMD_OP_HI:`CMD_OP_LO] == 2'h2) begin
              // Shadow setup needs special mode and a fresh latch
              if (!mode_sync && !latch_held) begin
                state <= S_SH_DIVH;
              end else begin
                ev_refused <= 1'b1;
              end
            end else if (sw_wdata[`CMD_OP_HI:`CMD_OP_LO] == 2'h3) begin
              ev_refused <= 1'b1;
            end else if (latch_held) begin
              state <= S_DATA;
            end else begin
              state <= S_LATCH;
            end
          end
        end
        S_LATCH: begin
          dev_we <= 1'b1;
          dev_addr <= `DEV_CTL;
          dev_wdata <= make_ctl(cmd, 1'b1, 1'b0);
          latch_held <= 1'b1;
          state <= S_DATA;
        end
        S_DATA: begin
          dev_we <= 1'b1;
          dev_addr <= op_addr;
          dev_wdata <= op_data;
          state <= S_PGM;
        end
        S_PGM: begin
          // Separate write: enable only sticks once latch is already set
          dev_we <= 1'b1;
          dev_addr <= `DEV_CTL;
          dev_wdata <= make_ctl(cmd, 1'b1, 1'b1);
          timer_restart <= 1'b1;
          state <= cmd.auto_clear ? S_POLL_RD : S_WAIT;
        end
        S_WAIT: begin
          if (timer_expired && !timer_restart) state <= S_CLR_PGM;
        end
        S_POLL_RD: begin
          dev_re <= 1'b1;
          dev_addr <= `DEV_CTL;
          state <= S_POLL_CHK;
        end
        S_POLL_CHK: begin
          if (dev_re) begin
            state <= S_POLL_CHK;
          end else if (!dev_rdata[0]) begin
            state <= S_CLR_PGM;
          end else if (timer_expired) begin
            // A protected target never clears the enable by itself
            ev_timeout <= 1'b1;
            state <= S_CLR_PGM;
          end else begin
            state <= S_POLL_RD;
          end
        end
        S_CLR_PGM: begin
          dev_we <= 1'b1;
          dev_addr <= `DEV_CTL;
          dev_wdata <= make_ctl(cmd, 1'b1, 1'b0);
          // A timed-out operation always drops the latch as well
          if (cmd.keep_latch && shadow_phase == 2'h0 && !ev_timeout) begin
            state <= S_DONE;
          end else begin
            state <= S_CLR_LAT;
          end
        end
        S_CLR_LAT: begin
          dev_we <= 1'b1;
          dev_addr <= `DEV_CTL;
          dev_wdata <= make_ctl(cmd, 1'b0, 1'b0);
          latch_held <= 1'b0;
          if (shadow_phase == 2'h1) begin
            shadow_phase <= 2'h2;
            state <= S_LATCH;
          end else if (shadow_phase == 2'h2) begin
            state <= S_SH_PROT;
          end else begin
            state <= S_DONE;
          end
        end
        S_SH_DIVH: begin
          dev_we <= 1'b1;
          dev_addr <= `DEV_DIVH;
          dev_wdata <= DATA_W'(div_value[9:8]);
          state <= S_SH_DIVL;
        end
        S_SH_DIVL: begin
          dev_we <= 1'b1;
          dev_addr <= `DEV_DIVL;
          dev_wdata <= div_value[7:0];
          state <= S_SH_UNPROT;
        end
        S_SH_UNPROT: begin
          dev_we <= 1'b1;
          dev_addr <= `DEV_PROT;
          dev_wdata <= `PROT_OPEN_VALUE;
          state <= S_SH_SHOW;
        end
        S_SH_SHOW: begin
          // Clearing shadow_hide maps the shadow word; test bits stay one
          dev_we <= 1'b1;
          dev_addr <= `DEV_MCR;
          dev_wdata <= `MCR_SHOW_VALUE;
          cmd.op <= eeprom_ctl_pkg::OP_PROGRAM;
          cmd.byte_sel <= 1'b1;
          cmd.auto_clear <= 1'b0;
          cmd.keep_latch <= 1'b0;
          shadow_phase <= 2'h1;
          state <= S_LATCH;
        end
        S_SH_PROT: begin
          dev_we <= 1'b1;
          dev_addr <= `DEV_PROT;
          dev_wdata <= `PROT_CLOSED_VALUE;
          state <= S_DONE;
        end
        S_DONE: begin
          ev_done <= 1'b1;
          shadow_phase <= 2'h0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_done <= 1'b0;
      flag_timeout <= 1'b0;
      flag_refused <= 1'b0;
    end else begin
      flag_done <= ev_done | (flag_done & ~(status_clear & sw_wdata[`ST_DONE]));
      flag_timeout <= ev_timeout | (flag_timeout & ~(status_clear & sw_wdata[`ST_TIMEOUT]));
      flag_refused <= ev_refused | (flag_refused & ~(status_clear & sw_wdata[`ST_REFUSED]));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sw_rdata <= '0;
    end else if (sw_rd) begin
      case (sw_addr)
        `HREG_ADDR: sw_rdata <= 16'(op_addr);
        `HREG_DATA: sw_rdata <= 16'(op_data);
        `HREG_DIV: sw_rdata <= {6'h00, div_value};
        `HREG_STATUS: begin
          sw_rdata <= '0;
          sw_rdata[`ST_BUSY] <= state != S_IDLE;
          sw_rdata[`ST_DONE] <= flag_done;
          sw_rdata[`ST_TIMEOUT] <= flag_timeout;
          sw_rdata[`ST_LATCH_HELD] <= latch_held;
          sw_rdata[`ST_DIV_LOADED] <= div_loaded;
          sw_rdata[`ST_SPECIAL] <= ~mode_sync;
          sw_rdata[`ST_REFUSED] <= flag_refused;
        end
        default: sw_rdata <= '0;
      endcase
    end else begin
      sw_rdata <= '0;
    end
  end

  // Checks on what this controller drives
  logic ctl_wr;
  eeprom_ctl_pkg::ctl_s ctl_w;
  eeprom_ctl_pkg::ctl_s ctl_last;
  logic shadow_run;
  assign ctl_wr = dev_we && dev_addr == `DEV_CTL;
  assign ctl_w = dev_wdata;
  assign shadow_run = shadow_phase != 2'h0;

  always_ff @(posedge clk) begin
    if (srst) ctl_last <= '0;
    else if (ctl_wr) ctl_last <= ctl_w;
  end

  property p_pgm_needs_latch;
    @(posedge clk) disable iff (srst)
      ctl_wr && ctl_w.program_voltage_enable |-> ctl_last.address_data_latch_enable;
  endproperty
  a_pgm_needs_latch: assert property (p_pgm_needs_latch)
    else $error("enable written without latch set");

  property p_clear_enable_first;
    @(posedge clk) disable iff (srst)
      ctl_wr && ctl_last.program_voltage_enable |-> ctl_w.address_data_latch_enable;
  endproperty
  a_clear_enable_first: assert property (p_clear_enable_first)
    else $error("latch dropped together with enable");

  property p_div_before_array;
    @(posedge clk) disable iff (srst)
      dev_we && dev_addr == op_addr && state == S_PGM |-> div_loaded;
  endproperty
  a_div_before_array: assert property (p_div_before_array)
    else $error("array written before dividers");

  property p_init_after_reset;
    @(posedge clk) $fell(srst) |=> dev_we && dev_addr == `DEV_DIVH ##1
      dev_we && dev_addr == `DEV_DIVL;
  endproperty
  a_init_after_reset: assert property (p_init_after_reset)
    else $error("dividers not loaded right after reset");

  property p_timeout_clears;
    @(posedge clk) disable iff (srst)
      ev_timeout |-> ##[1:2] (ctl_wr && !ctl_w.program_voltage_enable)
        ##[1:2] (ctl_wr && !ctl_w.address_data_latch_enable);
  endproperty
  a_timeout_clears: assert property (p_timeout_clears)
    else $error("timeout did not clear enable and latch");

  property p_shadow_hi_keep;
    @(posedge clk) disable iff (srst)
      dev_we && dev_addr == `DEV_SHADOW_HI |-> dev_wdata[7:2] == `SHADOW_HI_KEEP;
  endproperty
  a_shadow_hi_keep: assert property (p_shadow_hi_keep)
    else $error("high shadow byte upper bits not kept at one");

  property p_unhide_special;
    @(posedge clk) disable iff (srst)
      dev_we && dev_addr == `DEV_MCR && !dev_wdata[`MCR_SHADOW_HIDE] |->
        !mode_sync && $past(dev_addr) == `DEV_PROT;
  endproperty
  a_unhide_special: assert property (p_unhide_special)
    else $error("shadow unhidden outside special mode");

  property p_reprotect;
    @(posedge clk) disable iff (srst)
      dev_we && dev_addr == `DEV_PROT && shadow_run |-> dev_wdata[`PROT_SHADOW_PROTECT];
  endproperty
  a_reprotect: assert property (p_reprotect)
    else $error("shadow left unprotected");

  sequence s_chain_start;
    state == S_IDLE && start_req && latch_held && sw_wdata[`CMD_OP_HI] == 1'b0;
  endsequence
  sequence s_data_write;
    dev_we && dev_addr == op_addr && !ctl_wr;
  endsequence
  property p_chain;
    @(posedge clk) disable iff (srst) s_chain_start |-> ##2 s_data_write;
  endproperty
  a_chain: assert property (p_chain)
    else $error("chained operation did not go straight to data");

  property p_auto_poll;
    @(posedge clk) disable iff (srst)
      ctl_wr && ctl_w.program_voltage_enable && cmd.auto_clear |-> ##1 dev_re;
  endproperty
  a_auto_poll: assert property (p_auto_poll)
    else $error("auto mode did not poll enable");

endmodule // eeprom_host_ctl

/* File: eeprom_ctl_defines.svh */
`ifndef EEPROM_CTL_DEFINES_SVH
`define EEPROM_CTL_DEFINES_SVH

// Host register map, word index on the software port
`define HREG_CMD 4'h0
`define HREG_ADDR 4'h1
`define HREG_DATA 4'h2
`define HREG_DIV 4'h3
`define HREG_STATUS 4'h4

// Command word fields
`define CMD_START 0
`define CMD_OP_LO 1
`define CMD_OP_HI 2
`define CMD_AUTO 3
`define CMD_BYTE 4
`define CMD_ROW 5
`define CMD_KEEP_LATCH 6
`define CMD_BULK_PROTECT 7

// Status word fields
`define ST_BUSY 0
`define ST_DONE 1
`define ST_TIMEOUT 2
`define ST_LATCH_HELD 3
`define ST_DIV_LOADED 4
`define ST_SPECIAL 5
`define ST_REFUSED 6

// Device register addresses on the device bus
`define DEV_MCR 16'h00F0
`define DEV_PROT 16'h00F1
`define DEV_CTL 16'h00F3
`define DEV_DIVH 16'h00EE
`define DEV_DIVL 16'h00EF
`define DEV_SHADOW_HI 16'h0FC0
`define DEV_SHADOW_LO 16'h0FC1

// Field positions and widths inside device registers
`define MCR_DEBUG_LOCKOUT 7
`define MCR_SHADOW_HIDE 6
`define PROT_SHADOW_PROTECT 7
`define DIVH_W 2

// Values written to the device
`define MCR_SHOW_VALUE 8'hBF
`define PROT_OPEN_VALUE 8'h7F
`define PROT_CLOSED_VALUE 8'hFF
`define SHADOW_HI_KEEP 6'h3F

// Timing
`define CLK_PERIOD_NS 10
`define NS_PER_US 1000
`define PROGRAM_TIME_US 10000
`define POLL_TIMEOUT_US 20000
`define DIV_DEFAULT 10'h000

`endif

/* File: eeprom_ctl_pkg.sv */
package eeprom_ctl_pkg;

  typedef enum logic [1:0] {
    OP_PROGRAM,
    OP_ERASE,
    OP_SHADOW,
    OP_NONE
  } op_e;

  // Device control register image
  typedef struct packed {
    logic bulk_protect;
    logic rsvd;
    logic auto_clear;
    logic byte_sel;
    logic row_sel;
    logic erase;
    logic address_data_latch_enable;
    logic program_voltage_enable;
  } ctl_s;

  typedef struct packed {
    op_e op;
    logic auto_clear;
    logic byte_sel;
    logic row_sel;
    logic keep_latch;
    logic bulk_protect;
  } cmd_s;

endpackage

/* File: tick_divider.sv */
`timescale 1ns/100ps
`include "eeprom_ctl_defines.svh"

// One-cycle enable every DIV clocks
module tick_divider #(
  parameter int DIV = `NS_PER_US / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic srst,
  output logic tick
);
  logic [$clog2(DIV+1)-1:0] cnt;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == ($clog2(DIV+1))'(DIV - 1)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // tick_divider

/* File: tick_timer.sv */
`timescale 1ns/100ps

// Counts enable pulses from a restart up to a limit
module tick_timer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic restart,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic expired
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk) begin
    if (srst || restart) begin
      cnt <= '0;
      expired <= 1'b0;
    end else if (tick && !expired) begin
      cnt <= cnt + 1'b1;
      // The free-running tick has an unknown phase at restart, so count one
      // extra tick to guarantee at least limit full periods
      expired <= (cnt + 1'b1) > limit;
    end
  end
endmodule // tick_timer

/* File: eeprom_dev_model.sv */
`timescale 1ns/100ps
`include "eeprom_ctl_defines.svh"

module eeprom_dev_model #(
  parameter logic [15:0] SHADOW_INIT = 16'hFF00,
  parameter int AUTO_CYCLES = 150
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic special_mode_n,
  input wire logic lock_all,
  input wire logic [15:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_we,
  input wire logic dev_re,
  output logic [7:0] dev_rdata
);
  eeprom_ctl_pkg::ctl_s ctl, wr_ctl, run_ctl;
  logic [7:0] mcr, prot, sh_hi, sh_lo, divl, lat_data;
  logic [1:0] divh;
  logic [15:0] lat_addr;
  logic [9:0] loaded_div;
  logic divh_lk, divl_lk, running, prot_hit;
  int run_cnt, pgm_len = 0, viol = 0, array_writes = 0;

  initial begin
    sh_hi = SHADOW_INIT[15:8];
    sh_lo = SHADOW_INIT[7:0];
    dev_rdata = 8'h00;
  end
  assign wr_ctl = eeprom_ctl_pkg::ctl_s'(dev_wdata);
  assign prot_hit = lock_all || (prot[`PROT_SHADOW_PROTECT] &&
    (lat_addr == `DEV_SHADOW_HI || lat_addr == `DEV_SHADOW_LO));

  // Shadow only changes while visible, so a missed unhide shows up as stale contents
  task automatic commit();
    if (running && !mcr[`MCR_SHADOW_HIDE]) begin
      if (lat_addr == `DEV_SHADOW_HI) sh_hi <= run_ctl.erase ? 8'hFF : lat_data;
      if (lat_addr == `DEV_SHADOW_LO) sh_lo <= run_ctl.erase ? 8'hFF : lat_data;
    end
    running <= 1'b0;
  endtask

  always @(posedge clk) begin
    if (srst) begin
      mcr <= {sh_hi[7:4], 4'hF};
      divh <= sh_hi[1:0];
      divl <= sh_lo;
      loaded_div <= {sh_hi[1:0], sh_lo};
      prot <= 8'hFF;
      ctl <= '0;
      divh_lk <= 1'b0;
      divl_lk <= 1'b0;
      running <= 1'b0;
    end else begin
      if (ctl.program_voltage_enable) pgm_len <= pgm_len + 1;
      if (running && run_cnt > 0) run_cnt <= run_cnt - 1;
      if (running && run_cnt == 1 && ctl.auto_clear) begin
        ctl.program_voltage_enable <= 1'b0;
        commit();
      end
      if (dev_we) begin
        case (dev_addr)
          `DEV_CTL: if (ctl.program_voltage_enable) begin
            if (wr_ctl[7:1] != ctl[7:1]) viol <= viol + 1;
            if (!wr_ctl.program_voltage_enable) begin
              ctl.program_voltage_enable <= 1'b0;
              commit();
            end
          end else begin
            ctl <= wr_ctl;
            if (wr_ctl.program_voltage_enable && !ctl.address_data_latch_enable) begin
              ctl.program_voltage_enable <= 1'b0;
              viol <= viol + 1;
            end else if (wr_ctl.program_voltage_enable) begin
              pgm_len <= 0;
              run_ctl <= wr_ctl;
              running <= !prot_hit;
              run_cnt <= AUTO_CYCLES;
            end
          end
          `DEV_MCR: mcr <= dev_wdata;
          `DEV_PROT: prot <= dev_wdata;
          `DEV_DIVH: if (!divh_lk || !special_mode_n) begin
            divh <= dev_wdata[1:0];
            divh_lk <= 1'b1;
          end
          `DEV_DIVL: if (!divl_lk || !special_mode_n) begin
            divl <= dev_wdata;
            divl_lk <= 1'b1;
          end
          default: if (ctl.program_voltage_enable || !ctl.address_data_latch_enable) begin
            viol <= viol + 1;
          end else begin
            lat_addr <= dev_addr;
            lat_data <= dev_wdata;
            array_writes <= array_writes + 1;
          end
        endcase
      end
    end
  end

  // Released read data is inverted each cycle so a late sample cannot pass by luck
  always @(posedge clk) begin
    if (dev_re) begin
      case (dev_addr)
        `DEV_CTL: dev_rdata <= ctl;
        `DEV_MCR: dev_rdata <= mcr;
        `DEV_PROT: dev_rdata <= prot;
        `DEV_DIVH: dev_rdata <= {6'h00, divh};
        `DEV_DIVL: dev_rdata <= divl;
        `DEV_SHADOW_HI: dev_rdata <= mcr[`MCR_SHADOW_HIDE] ? 8'hFF : sh_hi;
        `DEV_SHADOW_LO: dev_rdata <= mcr[`MCR_SHADOW_HIDE] ? 8'hFF : sh_lo;
        default: dev_rdata <= 8'hFF;
      endcase
    end else begin
      dev_rdata <= ~dev_rdata;
    end
  end
endmodule // eeprom_dev_model

/* File: tb.sv */
`timescale 1ns/100ps
`include "eeprom_ctl_defines.svh"

module tb;
  logic clk = 0, srst = 1, sw_wr = 0, sw_rd = 0, special_mode_n = 1, lock_all = 0;
  logic [3:0] sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000, sw_rdata, dev_addr, rd;
  logic [7:0] dev_wdata, dev_rdata;
  logic dev_we, dev_re;
  int num_errors = 0, total_checks = 0, n0, k;

  always #5 clk = ~clk;

  eeprom_host_ctl #(.PROGRAM_CYCLES_US(3), .POLL_TIMEOUT_US(5), .DIV_RESET(10'h2A5)) dut (
    .clk(clk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .special_mode_n(special_mode_n),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_we(dev_we), .dev_re(dev_re),
    .dev_rdata(dev_rdata));

  eeprom_dev_model dev (
    .clk(clk), .srst(srst), .special_mode_n(special_mode_n), .lock_all(lock_all),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_we(dev_we), .dev_re(dev_re),
    .dev_rdata(dev_rdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  // Polls busy with a bound, then checks and clears the sticky status bits
  task automatic run(input logic [15:0] cmd, input logic [15:0] exp_st);
    int i;
    wr(`HREG_CMD, cmd);
    for (i = 0; i < 3000; i++) begin
      rd16(`HREG_STATUS, rd);
      if (rd[`ST_BUSY] === 1'b0) break;
    end
    repeat (4) @(posedge clk);
    rd16(`HREG_STATUS, rd);
    chk(rd, exp_st, "status");
    wr(`HREG_STATUS, 16'h0046);
  endtask

  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    do_reset();
    chk({6'h00, dev.divh, dev.divl}, 16'h02A5, "divider after reset");
    rd16(`HREG_STATUS, rd);
    chk(rd, 16'h0010, "idle status");
    rd16(4'hF, rd);
    chk(rd, 16'h0000, "unmapped read");
    wr(`HREG_ADDR, 16'h0123);
    wr(`HREG_DATA, 16'h005A);
    rd16(`HREG_ADDR, rd);
    chk(rd, 16'h0123, "address readback");
    rd16(`HREG_DATA, rd);
    chk(rd, 16'h005A, "data readback");
    run(16'h0091, 16'h0012);
    chk(dev.lat_addr, 16'h0123, "latched address");
    chk({8'h00, dev.lat_data}, 16'h005A, "latched data");
    chk({15'h0, dev.pgm_len >= 300}, 16'h0001, "manual hold");
    chk({8'h00, dev.ctl}, 16'h0090, "control idle");
    run(16'h0019, 16'h0012);
    chk({15'h0, dev.pgm_len < 300}, 16'h0001, "auto finished early");
    chk({8'h00, dev.ctl}, 16'h0030, "control idle after auto");
    lock_all <= 1'b1;
    run(16'h0059, 16'h0016);
    chk({15'h0, dev.pgm_len >= 500}, 16'h0001, "no self clear");
    chk({8'h00, dev.ctl}, 16'h0030, "cleared after timeout");
    lock_all <= 1'b0;
    n0 = dev.array_writes;
    wr(`HREG_ADDR, 16'h0010);
    wr(`HREG_DATA, 16'h0011);
    run(16'h0051, 16'h001A);
    chk({8'h00, dev.ctl}, 16'h0012, "latch kept");
    wr(`HREG_DATA, 16'h0022);
    run(16'h0011, 16'h0012);
    chk(16'(dev.array_writes - n0), 16'h0002, "chained writes");
    chk({8'h00, dev.lat_data}, 16'h0022, "second data");
    chk({8'h00, dev.ctl}, 16'h0010, "latch released");
    for (k = 0; k < 3; k++) begin
      run(16'h0003 | (16'(k[1]) << 4) | (16'(k[0]) << 5), 16'h0012);
      chk({13'h0, dev.run_ctl[4:2]}, {13'h0, k[1], k[0], 1'b1}, "erase size");
    end
    wr(`HREG_CMD, 16'h0005);
    rd16(`HREG_STATUS, rd);
    chk(rd, 16'h0050, "shadow refused");
    wr(`HREG_STATUS, 16'h0046);
    wr(`HREG_CMD, 16'h0007);
    rd16(`HREG_STATUS, rd);
    chk(rd, 16'h0050, "op three refused");
    wr(`HREG_STATUS, 16'h0046);
    chk(16'(dev.viol), 16'h0000, "device order");
    special_mode_n <= 1'b0;
    repeat (4) @(posedge clk);
    wr(`HREG_DIV, 16'h0137);
    rd16(`HREG_DIV, rd);
    chk(rd, 16'h0137, "divider readback");
    run(16'h0005, 16'h0032);
    chk({8'h00, dev.sh_hi}, 16'h00FD, "shadow high");
    chk({8'h00, dev.sh_lo}, 16'h0037, "shadow low");
    chk({15'h0, dev.prot[7]}, 16'h0001, "shadow protected");
    special_mode_n <= 1'b1;
    do_reset();
    chk({6'h00, dev.loaded_div}, 16'h0137, "shadow reload");
    chk({15'h0, dev.mcr[6]}, 16'h0001, "shadow hidden");
    chk({6'h00, dev.divh, dev.divl}, 16'h02A5, "first write wins");
    wrap_up();
  end
endmodule // tb
